// [dwi_regs.svh]
// constants of the dual wiper two-wire control block
`ifndef DWI_REGS_SVH
`define DWI_REGS_SVH
`define DWI_ADDR_PREFIX   4'h5
`define DWI_OP_VOL_WRITE  4'h1
`define DWI_OP_NV_WRITE   4'h2
`define DWI_OP_RECALL     4'h6
`define DWI_OP_STORE      4'h5
`define DWI_TGT_A         4'h1
`define DWI_TGT_B         4'h2
`define DWI_TGT_BOTH      4'h3
`define DWI_MIDSCALE      8'h80
`define DWI_BIT_LAST      4'h7
`define DWI_BIT_ACK       4'h8
`define DWI_INIT_TIME_NS  10000
`define DWI_CLK_NS        40
`define DWI_INIT_CYCLES   ((`DWI_INIT_TIME_NS) / (`DWI_CLK_NS))
`endif

// [dwi_pkg.sv]
// types of the dual wiper two-wire control block
package dwi_pkg;
  typedef enum logic [1:0] {
    DWI_PH_ADDR,
    DWI_PH_CMD,
    DWI_PH_DATA,
    DWI_PH_IDLE
  } dwi_phase_t;

  typedef struct packed {
    logic [3:0] op;
    logic [3:0] tgt;
    logic [7:0] data;
  } dwi_cmd_t;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
  } dwi_pair_t;
endpackage

// [dwi_ctrl.sv]
// dual wiper two-wire serial slave with nonvolatile copies
// Functional notes
// - idle bus has both lines released high; device leaves data released.
// - start is data falling while clock high; resets byte framing.
// - stop is data rising while clock high; frees the bus.
// - one bit per clock pulse, sampled on clock rise, stable while high.
// - ninth pulse carries acknowledge; device pulls data low during it.
// - clock is input only; data driven open-drain by the device.
// - answer only to seven-bit address with top four bits 0101.
// - low three address bits come from straps bit2, bit1, bit0.
// - eighth address bit zero means write; one means no-operation.
// - transfer is start, address, command, data, stop, all acknowledged.
// - first byte after address is command; next byte is data.
// - upper nibble picks operation, lower nibble picks wiper A, B, both.
// - volatile write loads data into selected wipers at once.
// - nonvolatile write stores data, wipers unchanged.
// - recall copies selected nonvolatile bytes into wipers.
// - store copies selected wipers into nonvolatile bytes.
// - nonvolatile store is two bytes, both midscale initially.
// - write protect high blocks nonvolatile writes and direct wiper writes.
// - write protect low permits all writes and both wiper update paths.
// - at power-up wipers load from store within 10 us before commands.
// - the system clock domain keeps running outside programming transfers.
`timescale 1ns/10ps
`include "dwi_regs.svh"
`default_nettype none
module dwi_ctrl (
  input  wire logic           clk,             // system clock, 25 MHz
  input  wire logic           rst,             // power-on reset, active high
  input  wire logic           scl_clk,         // serial clock from the master
  input  wire logic           sda_in,          // data line level
  output logic                sda_out,         // data drive value, always low
  output logic                sda_oe,          // high while pulling data low
  input  wire logic           addr_strap_bit0, // address strap bit 0
  input  wire logic           addr_strap_bit1, // address strap bit 1
  input  wire logic           addr_strap_bit2, // address strap bit 2
  input  wire logic           write_protect,   // high or floating blocks writes
  output dwi_pkg::dwi_pair_t  wiper_pos,       // volatile wiper positions
  output dwi_pkg::dwi_pair_t  nv_store,        // nonvolatile copies
  output logic                init_done,       // power-up load finished
  output logic                busy             // transfer in progress
);
  import dwi_pkg::*;

  // link domain, clocked by scl_clk
  // start/stop sensed on data edges; reset of framing is local to the link
  logic       start_tog_reg;
  logic       stop_tog_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  dwi_phase_t phase_reg;
  logic       ack_en_reg;
  logic       noop_reg;
  dwi_cmd_t   cmd_reg;
  logic       req_tog_reg;
  logic       start_seen_s;
  logic       start_seen_ack;

  // start: data falls while clock high
  always_ff @(negedge sda_in or posedge rst) begin
    if (rst) begin
      start_tog_reg <= 1'b0;
    end else if (scl_clk) begin
      start_tog_reg <= ~start_tog_reg;
    end
  end

  // stop: data rises while clock high
  always_ff @(posedge sda_in or posedge rst) begin
    if (rst) begin
      stop_tog_reg <= 1'b0;
    end else if (scl_clk) begin
      stop_tog_reg <= ~stop_tog_reg;
    end
  end

  // a start pending since the last clock rise, seen as a toggle mismatch
  logic start_ack_reg;
  assign start_seen_s = start_tog_reg ^ start_ack_reg;
  assign start_seen_ack = start_tog_reg;

  // bit framing on clock rise; one bit per pulse
  always_ff @(posedge scl_clk or posedge rst) begin
    if (rst) begin
      start_ack_reg <= 1'b0;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      phase_reg     <= DWI_PH_IDLE;
      noop_reg      <= 1'b0;
      cmd_reg       <= '0;
      req_tog_reg   <= 1'b0;
    end else begin
      start_ack_reg <= start_seen_ack;
      if (start_seen_s) begin
        // first bit after a fresh start
        bit_cnt_reg <= 4'h1;
        shift_reg   <= {7'h00, sda_in};
        phase_reg   <= DWI_PH_ADDR;
      end else if (bit_cnt_reg == `DWI_BIT_ACK) begin
        // ninth pulse closes the byte
        bit_cnt_reg <= 4'h0;
      end else begin
        shift_reg   <= {shift_reg[6:0], sda_in};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (bit_cnt_reg == `DWI_BIT_LAST) begin
          case (phase_reg)
            DWI_PH_ADDR: begin
              // address match and read/write select
              if (addr_ok({shift_reg[6:0], sda_in})) begin
                noop_reg  <= sda_in;
                phase_reg <= DWI_PH_CMD;
              end else begin
                phase_reg <= DWI_PH_IDLE;
              end
            end
            DWI_PH_CMD: begin
              // first byte after address is the command
              cmd_reg.op  <= shift_reg[6:3];
              cmd_reg.tgt <= {shift_reg[2:0], sda_in};
              phase_reg   <= DWI_PH_DATA;
            end
            DWI_PH_DATA: begin
              // first data byte hands a request over; later bytes ignored
              cmd_reg.data <= {shift_reg[6:0], sda_in};
              if (!noop_reg) begin
                req_tog_reg <= ~req_tog_reg;
              end
              phase_reg <= DWI_PH_IDLE;
            end
            default: begin
              phase_reg <= DWI_PH_IDLE;
            end
          endcase
        end
      end
    end
  end

  // address compare against fixed prefix and straps
  function automatic logic addr_ok(input logic [7:0] b);
    addr_ok = (b[7:4] == `DWI_ADDR_PREFIX) &&
              (b[3:1] == {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0});
  endfunction

  // acknowledge is driven from clock fall so it is stable through the high phase
  always_ff @(negedge scl_clk or posedge rst) begin
    if (rst) begin
      ack_en_reg <= 1'b0;
    end else begin
      ack_en_reg <= (bit_cnt_reg == `DWI_BIT_ACK) && !start_seen_s &&
                    (phase_reg != DWI_PH_IDLE || data_just_done());
    end
  end

  // data byte still acknowledged even though phase has moved to idle
  logic data_done_reg;
  always_ff @(posedge scl_clk or posedge rst) begin
    if (rst) begin
      data_done_reg <= 1'b0;
    end else begin
      data_done_reg <= (phase_reg == DWI_PH_DATA) && (bit_cnt_reg == `DWI_BIT_LAST);
    end
  end
  function automatic logic data_just_done();
    data_just_done = data_done_reg;
  endfunction

  // system domain, clocked by clk
  logic [2:0]  req_sync_reg;
  logic [1:0]  stop_sync_reg;
  logic [1:0]  start_sync_reg;
  logic [1:0]  wp_sync_reg;
  logic [1:0]  ack_sync_reg;
  dwi_cmd_t    cmd_hold_reg;
  dwi_pair_t   wiper_reg;
  dwi_pair_t   nv_reg;
  logic [8:0]  init_cnt_reg;
  logic        init_done_reg;
  logic        busy_reg;
  logic        req_pulse;
  logic        sel_a;
  logic        sel_b;
  logic        tgt_ok;

  // pin levels pass two flip-flops before use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_sync_reg   <= 3'h0;
      stop_sync_reg  <= 2'h0;
      start_sync_reg <= 2'h0;
      wp_sync_reg    <= 2'h3;
      ack_sync_reg   <= 2'h0;
    end else begin
      req_sync_reg   <= {req_sync_reg[1:0], req_tog_reg};
      stop_sync_reg  <= {stop_sync_reg[0], stop_tog_reg};
      start_sync_reg <= {start_sync_reg[0], start_tog_reg};
      wp_sync_reg    <= {wp_sync_reg[0], write_protect};
      ack_sync_reg   <= {ack_sync_reg[0], ack_en_reg};
    end
  end
  assign req_pulse = req_sync_reg[2] ^ req_sync_reg[1];

  // command words are stable in the link domain long before the toggle lands
  logic [1:0] busy_seen_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_seen_reg <= 2'h0;
      busy_reg      <= 1'b0;
    end else begin
      busy_seen_reg <= {stop_sync_reg[1], start_sync_reg[1]};
      // busy from start to stop; standby otherwise
      if (start_sync_reg[1] != busy_seen_reg[0]) begin
        busy_reg <= 1'b1;
      end else if (stop_sync_reg[1] != busy_seen_reg[1]) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // power-up load timer, bounded by the init time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_cnt_reg  <= 9'h000;
      init_done_reg <= 1'b0;
    end else if (!init_done_reg) begin
      init_cnt_reg <= init_cnt_reg + 9'h001;
      if (init_cnt_reg == 9'(`DWI_INIT_CYCLES - 2)) begin
        init_done_reg <= 1'b1;
      end
    end
  end

  // decode target; unknown targets select nothing
  assign tgt_ok = (cmd_hold_reg.tgt == `DWI_TGT_A) || (cmd_hold_reg.tgt == `DWI_TGT_B) ||
                  (cmd_hold_reg.tgt == `DWI_TGT_BOTH);
  assign sel_a  = tgt_ok && cmd_hold_reg.tgt[0];
  assign sel_b  = tgt_ok && cmd_hold_reg.tgt[1];
  logic exec_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_hold_reg <= '0;
      exec_reg     <= 1'b0;
    end else begin
      exec_reg <= req_pulse && init_done_reg;
      if (req_pulse) begin
        cmd_hold_reg <= cmd_reg;
      end
    end
  end

  // nonvolatile copies: midscale factory content, writes only when unprotected
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nv_reg <= {`DWI_MIDSCALE, `DWI_MIDSCALE};
    end else if (exec_reg && !wp_sync_reg[1]) begin
      case (cmd_hold_reg.op)
        `DWI_OP_NV_WRITE: begin
          if (sel_a) nv_reg.a <= cmd_hold_reg.data;
          if (sel_b) nv_reg.b <= cmd_hold_reg.data;
        end
        `DWI_OP_STORE: begin
          if (sel_a) nv_reg.a <= wiper_reg.a;
          if (sel_b) nv_reg.b <= wiper_reg.b;
        end
        default: begin
        end
      endcase
    end
  end

  // volatile wipers: load from store at power-up, then commands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wiper_reg <= {`DWI_MIDSCALE, `DWI_MIDSCALE};
    end else if (!init_done_reg) begin
      wiper_reg <= nv_reg;
    end else if (exec_reg) begin
      case (cmd_hold_reg.op)
        `DWI_OP_VOL_WRITE: begin
          // direct byte write only while unprotected
          if (!wp_sync_reg[1] && sel_a) wiper_reg.a <= cmd_hold_reg.data;
          if (!wp_sync_reg[1] && sel_b) wiper_reg.b <= cmd_hold_reg.data;
        end
        `DWI_OP_RECALL: begin
          if (sel_a) wiper_reg.a <= nv_reg.a;
          if (sel_b) wiper_reg.b <= nv_reg.b;
        end
        default: begin
        end
      endcase
    end
  end

  // outputs straight from flip-flops; data line released unless acking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_out   <= 1'b0;
      wiper_pos <= '0;
      nv_store  <= '0;
      init_done <= 1'b0;
      busy      <= 1'b0;
    end else begin
      sda_out   <= 1'b0;
      wiper_pos <= wiper_reg;
      nv_store  <= nv_reg;
      init_done <= init_done_reg;
      busy      <= busy_reg;
    end
  end
  // ack must follow the link clock directly, so the enable is the link flop
  assign sda_oe = ack_en_reg;

  // assertions
  a_init_bound: assert property (@(posedge clk) disable iff (rst)
    !init_done_reg |-> init_cnt_reg < 9'(`DWI_INIT_CYCLES))
    else $error("init counter ran past its bound");
  a_init_time: assert property (@(posedge clk) disable iff (rst)
    !init_done_reg && init_cnt_reg == 9'(`DWI_INIT_CYCLES - 2) |-> ##1 init_done_reg)
    else $error("init did not finish in time");
  a_nv_protect: assert property (@(posedge clk) disable iff (rst)
    wp_sync_reg[1] && $past(wp_sync_reg[1]) |=> $stable(nv_reg))
    else $error("nonvolatile changed under protect");
  a_vol_write: assert property (@(posedge clk) disable iff (rst)
    exec_reg && init_done_reg && !wp_sync_reg[1] && cmd_hold_reg.op == `DWI_OP_VOL_WRITE &&
    sel_a |=> wiper_reg.a == $past(cmd_hold_reg.data))
    else $error("volatile write lost");
  a_recall_b: assert property (@(posedge clk) disable iff (rst)
    exec_reg && init_done_reg && cmd_hold_reg.op == `DWI_OP_RECALL && sel_b
    |=> wiper_reg.b == $past(nv_reg.b))
    else $error("recall failed");
  a_bad_tgt: assert property (@(posedge clk) disable iff (rst)
    exec_reg && init_done_reg && !tgt_ok |=> $stable(wiper_reg) && $stable(nv_reg))
    else $error("unknown target changed state");
  a_nv_wiper: assert property (@(posedge clk) disable iff (rst)
    init_done_reg && exec_reg && cmd_hold_reg.op == `DWI_OP_NV_WRITE |=> $stable(wiper_reg))
    else $error("nv write moved wiper");
  a_store_a: assert property (@(posedge clk) disable iff (rst)
    exec_reg && !wp_sync_reg[1] && cmd_hold_reg.op == `DWI_OP_STORE && sel_a
    |=> nv_reg.a == $past(wiper_reg.a))
    else $error("store failed");
  a_ack_slot: assert property (@(posedge scl_clk) disable iff (rst)
    bit_cnt_reg != `DWI_BIT_ACK |-> !ack_en_reg)
    else $error("ack outside ninth pulse");

  // wipers follow the store until the power-up load is over
  a_init_wiper: assert property (@(posedge clk) disable iff (rst)
    !init_done_reg |=> wiper_reg == $past(nv_reg))
    else $error("power-up load missed");
  // a no-operation address must never hand a request over
  a_noop_quiet: assert property (@(posedge scl_clk) disable iff (rst)
    noop_reg |=> $stable(req_tog_reg))
    else $error("no-operation frame issued a request");
  // a foreign address drops the frame so nothing further is acked
  a_nack_addr: assert property (@(posedge scl_clk) disable iff (rst)
    !start_seen_s && phase_reg == DWI_PH_ADDR && bit_cnt_reg == `DWI_BIT_LAST &&
    !addr_ok({shift_reg[6:0], sda_in}) |=> phase_reg == DWI_PH_IDLE)
    else $error("foreign address accepted");
  // busy rises on a start and falls on a stop
  a_busy_start: assert property (@(posedge clk) disable iff (rst)
    start_sync_reg[1] != busy_seen_reg[0] |=> busy_reg)
    else $error("start did not raise busy");
  a_busy_stop: assert property (@(posedge clk) disable iff (rst)
    stop_sync_reg[1] != busy_seen_reg[1] && start_sync_reg[1] == busy_seen_reg[0]
    |=> !busy_reg)
    else $error("stop did not clear busy");
  a_nv_write_b: assert property (@(posedge clk) disable iff (rst)
    exec_reg && !wp_sync_reg[1] && cmd_hold_reg.op == `DWI_OP_NV_WRITE && sel_b
    |=> nv_reg.b == $past(cmd_hold_reg.data))
    else $error("nonvolatile write lost");
endmodule
`default_nettype wire

// [dwi_master.sv]
// bus master model: makes the serial clock and drives data open-drain
`timescale 1ns/10ps
`default_nettype none
module dwi_master (
  output logic      scl_clk,  // serial clock, still outside frames
  output logic      sda_pull, // high while pulling data low
  input  wire logic sda_line  // resolved data line level
);
  // clock driven high and data released while idle, so the pull-up holds data high
  initial begin
    scl_clk = 1'b1;
    sda_pull = 1'b0;
  end

  // one bit per pulse; data moves only while the clock is low
  task automatic put_bit(input logic b, output logic seen);
    begin
      sda_pull = ~b;
      #10 scl_clk = 1'b1;
      #7 seen = sda_line;
      #8 scl_clk = 1'b0;
      #5;
    end
  endtask

  // eight bits msb first, then a released ninth pulse; low there is ack
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic unused;
    begin
      for (int i = 7; i >= 0; i--) put_bit(b[i], unused);
      put_bit(1'b1, ack);
      ack = ~ack;
    end
  endtask

  // start, nb bytes, stop; acks come back msb first, unused ones 0
  task automatic frame(input logic [31:0] bytes, input int nb, output logic [3:0] acks);
    begin
      acks = 4'h0;
      #100 sda_pull = 1'b1; // data falls while the clock is high
      #100 scl_clk = 1'b0;
      #5;
      for (int k = 0; k < nb; k++) put_byte(bytes[31-8*k -: 8], acks[3-k]);
      sda_pull = 1'b1;
      #10 scl_clk = 1'b1;
      #100 sda_pull = 1'b0; // data rises while the clock is high
      #200;
    end
  endtask
endmodule
`default_nettype wire

// [dwi_ctrl_bench.sv]
// self-checking bench for the dual wiper two-wire control block
`timescale 1ns/10ps
`include "dwi_regs.svh"
`default_nettype none
`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module dwi_ctrl_bench;
  import dwi_pkg::*;
  logic      clk, rst, scl_clk, sda_pull, sda_out, sda_oe, wp, init_done, busy;
  logic [2:0] strap;
  wire logic sda_line;
  dwi_pair_t wiper_pos, nv_store, exp_w, exp_nv;
  logic [3:0] acks;
  int        errors, compares;

  // open-drain wire with pull-up: low if anyone pulls
  assign sda_line = ((sda_oe && !sda_out) || sda_pull) ? 1'b0 : 1'b1;

  always #20 clk = ~clk;

  dwi_ctrl dwi_ctrl_inst (.clk(clk), .rst(rst), .scl_clk(scl_clk), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_bit0(strap[0]),
    .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]), .write_protect(wp),
    .wiper_pos(wiper_pos), .nv_store(nv_store), .init_done(init_done), .busy(busy));
  dwi_master dwi_master_inst (.scl_clk(scl_clk), .sda_pull(sda_pull), .sda_line(sda_line));

  // expected effect of one accepted command on the wipers and the store
  function automatic void model(logic [3:0] op, logic [3:0] tgt, logic [7:0] d);
    logic ha, hb;
    ha = (tgt == `DWI_TGT_A) || (tgt == `DWI_TGT_BOTH);
    hb = (tgt == `DWI_TGT_B) || (tgt == `DWI_TGT_BOTH);
    case (op)
      `DWI_OP_VOL_WRITE: if (!wp) exp_w = {ha ? d : exp_w.a, hb ? d : exp_w.b};
      `DWI_OP_NV_WRITE: if (!wp) exp_nv = {ha ? d : exp_nv.a, hb ? d : exp_nv.b};
      `DWI_OP_RECALL: exp_w = {ha ? exp_nv.a : exp_w.a, hb ? exp_nv.b : exp_w.b};
      `DWI_OP_STORE: if (!wp) exp_nv = {ha ? exp_w.a : exp_nv.a, hb ? exp_w.b : exp_nv.b};
      default: ; // unknown codes change nothing
    endcase
  endfunction

  // one frame, then a settle time covering the crossing into the clk domain
  task automatic run(input logic [6:0] adr, input logic nop, input logic [3:0] op,
                     input logic [3:0] tgt, input logic [7:0] d, input int nb,
                     input logic [3:0] exp_acks);
    begin
      dwi_master_inst.frame({adr, nop, op, tgt, d, 8'h5A}, nb, acks);
      if (adr == {`DWI_ADDR_PREFIX, strap} && !nop) model(op, tgt, d);
      repeat (10) @(posedge clk);
      if (!nop) `CHK(acks, exp_acks);
      `CHK({wiper_pos, nv_store}, {exp_w, exp_nv});
      `CHK(busy, 1'b0);
      `CHK(sda_oe, 1'b0);
    end
  endtask

  task automatic t_init;
    int n;
    begin
      n = 0;
      while (init_done !== 1'b1 && n < 400) begin
        @(posedge clk);
        n++;
      end
      // one extra cycle: the loop sees the output flop one edge late
      `CHK(n <= `DWI_INIT_CYCLES + 1, 1'b1);
      if (n >= 400) give_verdict();
      `CHK({wiper_pos, nv_store}, {4{`DWI_MIDSCALE}});
      $display("test init done");
    end
  endtask

  task automatic t_volatile;
    logic [6:0] a;
    begin
      a = {`DWI_ADDR_PREFIX, strap};
      run(a, 1'b0, `DWI_OP_VOL_WRITE, `DWI_TGT_A, 8'h12, 3, 4'hE);
      run(a, 1'b0, `DWI_OP_VOL_WRITE, `DWI_TGT_B, 8'hFF, 3, 4'hE);
      run(a, 1'b0, `DWI_OP_VOL_WRITE, `DWI_TGT_BOTH, 8'h00, 3, 4'hE);
      $display("test volatile done");
    end
  endtask

  task automatic t_nonvolatile;
    logic [6:0] a;
    begin
      a = {`DWI_ADDR_PREFIX, strap};
      run(a, 1'b0, `DWI_OP_NV_WRITE, `DWI_TGT_A, 8'h3C, 3, 4'hE);
      run(a, 1'b0, `DWI_OP_NV_WRITE, `DWI_TGT_B, 8'hC3, 3, 4'hE);
      run(a, 1'b0, `DWI_OP_RECALL, `DWI_TGT_A, 8'h77, 3, 4'hE);
      run(a, 1'b0, `DWI_OP_VOL_WRITE, `DWI_TGT_B, 8'h11, 3, 4'hE);
      run(a, 1'b0, `DWI_OP_STORE, `DWI_TGT_B, 8'hEE, 4, 4'hE);
      run(a, 1'b0, `DWI_OP_VOL_WRITE, `DWI_TGT_BOTH, 8'h99, 3, 4'hE);
      run(a, 1'b0, `DWI_OP_STORE, `DWI_TGT_BOTH, 8'h01, 3, 4'hE);
      run(a, 1'b0, `DWI_OP_NV_WRITE, `DWI_TGT_BOTH, 8'h44, 3, 4'hE);
      run(a, 1'b0, `DWI_OP_RECALL, `DWI_TGT_BOTH, 8'h00, 3, 4'hE);
      $display("test nonvolatile done");
    end
  endtask

  task automatic t_protect;
    logic [6:0] a;
    begin
      a = {`DWI_ADDR_PREFIX, strap};
      run(a, 1'b0, `DWI_OP_VOL_WRITE, `DWI_TGT_A, 8'h21, 3, 4'hE);
      @(posedge clk);
      wp <= 1'b1;
      repeat (4) @(posedge clk); // let the two-flop synchroniser settle
      run(a, 1'b0, `DWI_OP_VOL_WRITE, `DWI_TGT_BOTH, 8'h5F, 3, 4'hE);
      run(a, 1'b0, `DWI_OP_NV_WRITE, `DWI_TGT_BOTH, 8'h6E, 3, 4'hE);
      run(a, 1'b0, `DWI_OP_STORE, `DWI_TGT_A, 8'h00, 3, 4'hE);
      run(a, 1'b0, `DWI_OP_RECALL, `DWI_TGT_A, 8'h00, 3, 4'hE);
      @(posedge clk);
      wp <= 1'b0;
      repeat (4) @(posedge clk);
      $display("test protect done");
    end
  endtask

  task automatic t_refuse;
    logic [6:0] a;
    begin
      a = {`DWI_ADDR_PREFIX, strap};
      for (int i = 0; i < 7; i++)
        run(a ^ (7'h01 << i), 1'b0, `DWI_OP_VOL_WRITE, `DWI_TGT_A, 8'hA0, 3, 4'h0);
      run(a, 1'b1, `DWI_OP_VOL_WRITE, `DWI_TGT_BOTH, 8'hB1, 3, 4'hE);
      run(a, 1'b0, 4'h3, `DWI_TGT_BOTH, 8'hC2, 3, 4'hE);
      run(a, 1'b0, `DWI_OP_VOL_WRITE, 4'h0, 8'hD3, 3, 4'hE);
      run(a, 1'b0, `DWI_OP_NV_WRITE, 4'h4, 8'hE4, 3, 4'hE);
      @(posedge clk);
      strap <= 3'b010;
      @(posedge clk);
      run(a, 1'b0, `DWI_OP_VOL_WRITE, `DWI_TGT_A, 8'hA5, 3, 4'h0);
      run({`DWI_ADDR_PREFIX, 3'b010}, 1'b0, `DWI_OP_VOL_WRITE, `DWI_TGT_A, 8'h5A, 3, 4'hE);
      $display("test refuse done");
    end
  endtask

  // single exit: counts, verdict, end of run
  task automatic give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    wp = 1'b0;
    strap = 3'b101;
    errors = 0;
    compares = 0;
    exp_w = {2{`DWI_MIDSCALE}};
    exp_nv = {2{`DWI_MIDSCALE}};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_init();
    t_volatile();
    t_nonvolatile();
    t_protect();
    t_refuse();
    give_verdict();
  end
endmodule
`default_nettype wire
